// ### rtl/complementary_output_control.sv
// Control slice of the complementary waveform generator: control registers,
// dead-band count buffers, generator clock selection and output pin stage.
// Assumes a plain register port, one clock, and a core that supplies the raw
// waveforms and a buffer_event pulse on each rising input event.
//
// Our own choices: the strobed register port and the register addresses.
`include "cog_defines.svh"
module complementary_output_control
  import cog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_active,
  input wire logic osc_tick,
  input wire logic buffer_event,
  input wire logic first_wave,
  input wire logic second_wave,
  output logic generator_enable,
  output logic push_pull_select,
  output logic rising_deadband_source,
  output logic falling_deadband_source,
  output cog_pkg::count_t rising_deadband_count,
  output cog_pkg::count_t falling_deadband_count,
  output logic generator_clock,
  output logic osc_keep_alive,
  output logic load_done,
  output logic first_drive_output,
  output logic first_drive_oe,
  output logic second_drive_output,
  output logic second_drive_oe
);
  import cog_pkg::*;

  ctl_s st_q; // Registered state
  ctl_s st_d; // Next state
  logic wr_c0; // Write to control zero
  logic wr_c1; // Write to control one
  logic wr_rc; // Write to rising count
  logic wr_fc; // Write to falling count
  logic xfer; // Staged counts move to working copies

  // ****************************************
  // Address decode
  // ****************************************
  assign wr_c0 = reg_wr && reg_addr == `OFS_CTRL_ZERO;
  assign wr_c1 = reg_wr && reg_addr == `OFS_CTRL_ONE;
  assign wr_rc = reg_wr && reg_addr == `OFS_RISE_COUNT;
  assign wr_fc = reg_wr && reg_addr == `OFS_FALL_COUNT;

  // Transfer happens on the core's own event so both counts change together
  assign xfer = st_q.en && st_q.ld && buffer_event;

  // ****************************************
  // Next state
  // ****************************************
  // Whole state freezes while clk_en is low; strobes then are lost
  always_comb
  begin
    st_d = st_q;
    if (clk_en)
    begin
      st_d.xfer_done = 1'b0;
      st_d.rdata = 8'h00;
      // Control zero fields
      if (wr_c0)
      begin
        st_d.en = reg_wdata[`C0_EN];
        st_d.oe1 = reg_wdata[`C0_OE1];
        st_d.oe0 = reg_wdata[`C0_OE0];
        st_d.inv1 = reg_wdata[`C0_INV1];
        st_d.inv0 = reg_wdata[`C0_INV0];
        st_d.pp = reg_wdata[`C0_PP];
      end
      // Hardware clear first, so a software set in the same cycle wins
      if (xfer)
      begin
        st_d.ld = 1'b0;
        st_d.rise_work = st_q.rise_stage;
        st_d.fall_work = st_q.fall_stage;
        st_d.xfer_done = 1'b1;
      end
      if (wr_c0)
        st_d.ld = reg_wdata[`C0_LD] | (st_q.ld & !xfer);
      // Control one fields; bits five to two are not stored
      if (wr_c1)
      begin
        st_d.rsrc = reg_wdata[`C1_RSRC];
        st_d.fsrc = reg_wdata[`C1_FSRC];
        st_d.cs = reg_wdata[`C1_CS_HI:`C1_CS_LO];
      end
      // Count staging; when stopped the working copy follows at once
      if (wr_rc)
      begin
        st_d.rise_stage = reg_wdata[`CNT_W-1:0];
        if (!st_q.en)
          st_d.rise_work = reg_wdata[`CNT_W-1:0];
      end
      if (wr_fc)
      begin
        st_d.fall_stage = reg_wdata[`CNT_W-1:0];
        if (!st_q.en)
          st_d.fall_work = reg_wdata[`CNT_W-1:0];
      end
      // Read data stand only in the cycle after the strobe
      if (reg_rd)
      begin
        unique case (reg_addr)
          `OFS_CTRL_ZERO: st_d.rdata = {st_q.en, st_q.oe1, st_q.oe0, st_q.inv1,
                                        st_q.inv0, st_q.ld, 1'b0, st_q.pp};
          `OFS_CTRL_ONE: st_d.rdata = {st_q.rsrc, st_q.fsrc, 4'h0, st_q.cs};
          `OFS_RISE_COUNT: st_d.rdata = 8'(st_q.rise_stage);
          `OFS_FALL_COUNT: st_d.rdata = 8'(st_q.fall_stage);
          // Unmapped addresses read as zero
          default: st_d.rdata = 8'h00;
        endcase
      end
      // Pin stage: invert per output, drive only while enabled
      st_d.out0 = first_wave ^ st_q.inv0;
      st_d.out1 = second_wave ^ st_q.inv1;
      st_d.pin_oe0 = st_q.en && st_q.oe0;
      st_d.pin_oe1 = st_q.en && st_q.oe1;
      // Oscillator must stay up in sleep only when it clocks a running generator
      st_d.osc_hold = st_d.en && st_d.cs == `CS_FAST;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ****************************************
  // Generator clock
  // ****************************************
  gen_clock_tick u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clock_sel(st_q.cs),
    .sleep_active(sleep_active),
    .osc_tick(osc_tick),
    .tick(generator_clock)
  );

  // ****************************************
  // Outputs, all straight from state flops
  // ****************************************
  assign reg_rdata = st_q.rdata;
  assign generator_enable = st_q.en;
  assign push_pull_select = st_q.pp;
  assign rising_deadband_source = st_q.rsrc;
  assign falling_deadband_source = st_q.fsrc;
  assign rising_deadband_count = st_q.rise_work;
  assign falling_deadband_count = st_q.fall_work;
  assign osc_keep_alive = st_q.osc_hold;
  assign load_done = st_q.xfer_done;
  assign first_drive_output = st_q.out0;
  assign second_drive_output = st_q.out1;
  assign first_drive_oe = st_q.pin_oe0;
  assign second_drive_oe = st_q.pin_oe1;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence load_armed;
    clk_en && st_q.en && st_q.ld && !wr_c0;
  endsequence

  sequence load_fires;
    load_armed ##0 buffer_event;
  endsequence

  chk_enable_follows: assert property (clk_en && wr_c0 |=> generator_enable == $past(reg_wdata[7])) else $error("enable did not follow write");
  chk_rise_source: assert property (clk_en && wr_c1 |=> rising_deadband_source == $past(reg_wdata[7])) else $error("rising source wrong");
  chk_fall_source: assert property (clk_en && wr_c1 |=> falling_deadband_source == $past(reg_wdata[6])) else $error("falling source wrong");
  chk_unimpl_zero: assert property (clk_en && reg_rd && reg_addr == `OFS_CTRL_ONE |=> reg_rdata[5:2] == 4'h0 && reg_rdata[1:0] == $past(st_q.cs)) else $error("control one read wrong");
  chk_fast_hold: assert property (clk_en && wr_c1 && reg_wdata[1:0] == `CS_FAST && st_q.en && !wr_c0 |=> osc_keep_alive) else $error("oscillator not held");
  chk_load_transfer: assert property (load_fires |=> rising_deadband_count == $past(st_q.rise_stage) && !st_q.ld && load_done) else $error("load transfer failed");
  chk_load_waits: assert property (clk_en && st_q.en && !xfer |=> $stable(rising_deadband_count) && $stable(falling_deadband_count)) else $error("working count moved without load");
  chk_direct_write: assert property (clk_en && !st_q.en && wr_rc |=> rising_deadband_count == $past(reg_wdata[`CNT_W-1:0])) else $error("disabled write not direct");
  chk_pin_invert: assert property (clk_en |=> first_drive_output == ($past(first_wave) ^ $past(st_q.inv0)) && second_drive_oe == $past(st_q.en && st_q.oe1)) else $error("pin stage wrong");

endmodule

// ### rtl/cog_defines.svh
// Constants for the complementary output control slice: offsets, field positions,
// reset values and clock select codes.
// Assumes it is included by bare name from the package and the design modules.
//
// Notes on behaviour
// - Enable bit seven runs or stops generator
// - Rising source bit picks delay chain or clock
// - Falling source bit picks delay chain or clock
// - Clock select: 00 system, 01 quarter, 11 reserved
// - Code 10 uses fast oscillator, runs in sleep
// - Control one bits five to two read zero
// - Load bit transfers counts on event, self-clears
// - Disabled: count writes go straight to working
`ifndef COG_DEFINES_SVH
`define COG_DEFINES_SVH

// ****************************************
// Register map (byte offsets on the plain port)
// ****************************************
`define OFS_CTRL_ZERO 4'h0
`define OFS_CTRL_ONE 4'h1
`define OFS_RISE_COUNT 4'h2
`define OFS_FALL_COUNT 4'h3

// ****************************************
// Field positions
// ****************************************
`define C0_EN 7
`define C0_OE1 6
`define C0_OE0 5
`define C0_INV1 4
`define C0_INV0 3
`define C0_LD 2
`define C0_PP 0
`define C1_RSRC 7
`define C1_FSRC 6
`define C1_CS_HI 1
`define C1_CS_LO 0

// ****************************************
// Reset values, widths and codes
// ****************************************
`define REG_RESET 8'h00
`define CNT_W 6
`define CS_SYS 2'h0
`define CS_DIV4 2'h1
`define CS_FAST 2'h2
`define CS_RSVD 2'h3
`define DIV4_LAST 2'h3

`endif

// ### rtl/cog_pkg.sv
// Types shared by the complementary output control slice.
// Assumes cog_defines.svh sits on the include path.
`include "cog_defines.svh"

package cog_pkg;

  // Width of one dead-band count
  typedef logic [`CNT_W-1:0] count_t;

  // All state of the control slice except the generator clock tick maker
  typedef struct packed {
    logic en;
    logic oe1;
    logic oe0;
    logic inv1;
    logic inv0;
    logic ld;
    logic pp;
    logic rsrc;
    logic fsrc;
    logic [1:0] cs;
    count_t rise_stage;
    count_t fall_stage;
    count_t rise_work;
    count_t fall_work;
    logic [7:0] rdata;
    logic out0;
    logic out1;
    logic pin_oe0;
    logic pin_oe1;
    logic osc_hold;
    logic xfer_done;
  } ctl_s;

  // State of the generator clock tick maker
  typedef struct packed {
    logic [1:0] div;
    logic tick;
  } tick_s;

endpackage

// ### rtl/gen_clock_tick.sv
// Generator clock tick maker: turns the clock select code into a one-cycle enable.
// Assumes osc_tick is a synchronous pulse from the fast oscillator and that the
// system clock derived ticks stop while sleep_active is high.
`include "cog_defines.svh"
module gen_clock_tick
  import cog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] clock_sel,
  input wire logic sleep_active,
  input wire logic osc_tick,
  output logic tick
);
  import cog_pkg::*;

  tick_s st_q;
  tick_s st_d;

  // ****************************************
  // Next state
  // ****************************************
  // Quarter rate counter runs freely so a code change needs no restart
  always_comb
  begin
    st_d = st_q;
    if (clk_en)
    begin
      st_d.div = st_q.div + 2'h1;
      unique case (clock_sel)
        `CS_SYS: st_d.tick = !sleep_active;
        `CS_DIV4: st_d.tick = !sleep_active && (st_q.div == `DIV4_LAST);
        // Oscillator keeps ticking in sleep, so the generator keeps going
        `CS_FAST: st_d.tick = osc_tick;
        // Reserved code gives no clock at all
        `CS_RSVD: st_d.tick = 1'b0;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tick = st_q.tick;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence div_run;
    clk_en && clock_sel == `CS_DIV4 && !sleep_active;
  endsequence

  // A tick seen only counts once the quarter code has already been in force a cycle,
  // since the tick right after a code change may still belong to the old code
  sequence div_tick_seen;
    clk_en && clock_sel == `CS_DIV4 && !sleep_active && tick;
  endsequence

  chk_div_four_period: assert property (div_run ##1 div_tick_seen ##1 div_run [*4]
    |-> tick && !$past(tick)) else $error("quarter rate tick period wrong");
  chk_reserved_quiet: assert property (clk_en && clock_sel == `CS_RSVD |=> !tick)
    else $error("reserved clock code ticked");
  chk_fast_in_sleep: assert property (clk_en && clock_sel == `CS_FAST && osc_tick |=> tick) else $error("oscillator tick lost");

endmodule

// ### verif/power_stage_model.sv
// Power stage model: two gate-driven switches fed by the two drive pins.
// Assumes each gate has a pull-down, so an undriven pin turns its switch off.
module power_stage_model
(
  input wire logic gate_a,
  input wire logic gate_a_oe,
  input wire logic gate_b,
  input wire logic gate_b_oe,
  output logic high_on,
  output logic low_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released gate falls to the pull-down level, never keeps the old value
  assign high_on = gate_a_oe & gate_a;
  assign low_on = gate_b_oe & gate_b;
endmodule

// ### verif/complementary_output_control_tb.sv
// Self-checking bench for the complementary output control slice.
// Assumes cog_defines.svh on the include path and the power stage model.
`include "cog_defines.svh"
module complementary_output_control_tb
  import cog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_active = 1'b0;
  logic osc_tick = 1'b0;
  logic buffer_event = 1'b0;
  logic first_wave = 1'b0;
  logic second_wave = 1'b0;
  logic [7:0] reg_rdata, d;
  logic en, pp, rsrc, fsrc, gclk, keep, ldone, o0, oe0, o1, oe1, hi, lo;
  count_t rcnt, fcnt;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  // Write then read back; unused bits and unmapped places read zero
  row_t rows [6] = '{'{4'h1, 8'hFF, 8'hC3}, '{4'h1, 8'h3C, 8'h00},
    '{4'h0, 8'h7B, 8'h79}, '{4'h2, 8'h3F, 8'h3F}, '{4'h3, 8'h15, 8'h15},
    '{4'h5, 8'hFF, 8'h00}};
  complementary_output_control i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_active(sleep_active),
    .osc_tick(osc_tick), .buffer_event(buffer_event), .first_wave(first_wave),
    .second_wave(second_wave), .generator_enable(en), .push_pull_select(pp),
    .rising_deadband_source(rsrc), .falling_deadband_source(fsrc),
    .rising_deadband_count(rcnt), .falling_deadband_count(fcnt),
    .generator_clock(gclk), .osc_keep_alive(keep), .load_done(ldone),
    .first_drive_output(o0), .first_drive_oe(oe0), .second_drive_output(o1),
    .second_drive_oe(oe1));
  power_stage_model i_stage (.gate_a(o0), .gate_a_oe(oe0), .gate_b(o1),
    .gate_b_oe(oe1), .high_on(hi), .low_on(lo));
  // Clock at 50 ns period
  always #25 ref_clk = ~ref_clk;
  // Oscillator pulse every 8 cycles; cycle ceiling cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    osc_tick <= (cyc[2:0] == 3'h0);
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ****************************************
  // Bus, compare and closing tasks
  // ****************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    if (s !== e)
      bad_count++;
  endtask
  // Strobe held one cycle; effect visible just after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Count generator clock ticks in a 16-cycle window
  task automatic ticks(input logic [1:0] cs, input logic [7:0] e);
    logic [7:0] n;
    wr(`OFS_CTRL_ONE, {6'h00, cs});
    repeat (2) @(posedge ref_clk);
    n = 8'h00;
    repeat (16)
    begin
      @(posedge ref_clk);
      #1 n = n + {7'h00, gclk};
    end
    chk(n, e);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`OFS_CTRL_ZERO);
    chk(d, `REG_RESET);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    chk({7'h00, pp}, 8'h01);
    $display("register table done");
    // Disabled: count writes reach the working counts at once
    wr(`OFS_RISE_COUNT, 8'h0A);
    chk({2'h0, rcnt}, 8'h0A);
    wr(`OFS_CTRL_ZERO, 8'h80);
    chk({7'h00, en}, 8'h01);
    wr(`OFS_RISE_COUNT, 8'h21);
    wr(`OFS_FALL_COUNT, 8'h12);
    chk({2'h0, rcnt}, 8'h0A);
    wr(`OFS_CTRL_ZERO, 8'h84);
    rd(`OFS_CTRL_ZERO);
    chk(d, 8'h84);
    @(posedge ref_clk);
    buffer_event <= 1'b1;
    @(posedge ref_clk);
    buffer_event <= 1'b0;
    #1 chk({ldone, 1'b0, rcnt}, 8'hA1);
    chk({2'h0, fcnt}, 8'h12);
    rd(`OFS_CTRL_ZERO);
    chk(d, 8'h80);
    chk({7'h00, ldone}, 8'h00);
    $display("buffer load done");
    wr(`OFS_CTRL_ONE, 8'hC0);
    chk({6'h00, rsrc, fsrc}, 8'h03);
    wr(`OFS_CTRL_ONE, 8'h40);
    chk({6'h00, rsrc, fsrc}, 8'h01);
    ticks(2'h0, 8'h10);
    ticks(2'h1, 8'h04);
    ticks(2'h3, 8'h00);
    ticks(2'h2, 8'h02);
    chk({7'h00, keep}, 8'h01);
    @(posedge ref_clk);
    sleep_active <= 1'b1;
    ticks(2'h0, 8'h00);
    chk({7'h00, keep}, 8'h00);
    ticks(2'h2, 8'h02);
    @(posedge ref_clk);
    sleep_active <= 1'b0;
    $display("clock select done");
    // Pins: first inverted, second plain, then second wave high
    wr(`OFS_CTRL_ZERO, 8'hE8);
    repeat (2) @(posedge ref_clk);
    #1 chk({4'h0, hi, lo, oe0, oe1}, 8'h0B);
    @(posedge ref_clk);
    second_wave <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, hi, lo}, 8'h03);
    wr(`OFS_CTRL_ZERO, 8'h80);
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, oe0, oe1}, 8'h00);
    $display("pin stage done");
    // Clock enable low freezes all state, so this write is lost
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`OFS_CTRL_ZERO, 8'h00);
    chk({7'h00, en}, 8'h01);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("clock enable done");
    // Second reset in mid-run clears the control fields
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 chk({7'h00, en}, 8'h00);
    rd(`OFS_CTRL_ONE);
    chk(d, `REG_RESET);
    $display("reset done");
    summarize();
  end
endmodule
